// ===== core/ppm_priority_mapper.v
`timescale 1ns/1ps
`include "ppm_regs.vh"

// one mapping register: reset default, address match, load on a completed write
module ppm_map_reg #(
    parameter [`PPM_ADDR_W-1:0] ADDR = 10'h000,
    parameter [7:0] RST_VAL = 8'h00
) (
    // clock and reset
    input wire i_ref_clk,
    input wire i_srst,
    // bus side
    input wire [`PPM_ADDR_W-1:0] i_address,
    input wire i_wr_take,
    input wire [7:0] i_wr_data,
    // decode and contents
    output wire o_hit,
    output reg [7:0] o_value
);

    // address match for this register
    assign o_hit = (i_address == ADDR);

    // contents change only at the edge that ends a write access
    always @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_value <= RST_VAL;
        end else if (i_wr_take && o_hit) begin
            o_value <= i_wr_data;
        end
    end

endmodule

// one 2-bit queue field of a mapping register and the code that selects it
module ppm_field_pick #(
    parameter POS = 0,
    parameter [2:0] CODE = 3'h0
) (
    // lookup side
    input wire [7:0] i_map,
    input wire [2:0] i_code,
    // field value and code match
    output wire [1:0] o_queue,
    output wire o_hit
);

    // fixed slice, 0 lowest queue, 3 highest
    assign o_queue = i_map[POS +: `PPM_FLD_W];

    // this field serves exactly one code value
    assign o_hit = (i_code == CODE);

endmodule

// bus handshake: one wait cycle per access, answer at the second edge
module ppm_avs_wait (
    // clock and reset
    input wire i_ref_clk,
    input wire i_srst,
    // request from the master
    input wire i_read,
    input wire i_write,
    // handshake outputs
    output wire o_waitrequest,
    output reg o_ack
);

    wire req;

    // either direction is a request; wait until acknowledged
    assign req = i_read | i_write;
    assign o_waitrequest = req & ~o_ack;

    // acknowledge toggles, so back-to-back requests each wait once
    always @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_ack <= 1'b0;
        end else begin
            o_ack <= req & ~o_ack;
        end
    end

endmodule

module ppm_priority_mapper (
    // clock and reset
    input wire i_ref_clk,
    input wire i_srst,
    // avalon-mm slave
    input wire [`PPM_ADDR_W-1:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    output reg [31:0] o_avs_readdata,
    output wire o_avs_waitrequest,
    // classification side
    input wire i_lookup_valid,
    input wire [2:0] i_priority_code,
    // queue side
    output reg o_queue_valid,
    output reg [1:0] o_queue_sel
);

    wire [7:0] map_low_q;
    wire [7:0] map_high_q;
    wire ack_q;
    wire hit_low;
    wire hit_high;
    wire wr_take;
    wire rd_load;
    reg [7:0] rdata_d;
    reg [1:0] queue_d;
    wire [1:0] queue_for_code_zero;
    wire [1:0] queue_for_code_one;
    wire [1:0] queue_for_code_two;
    wire [1:0] queue_for_code_three;
    wire [1:0] queue_for_code_four;
    wire [1:0] queue_for_code_five;
    wire [1:0] queue_for_code_six;
    wire [1:0] queue_for_code_seven;
    wire code_match_zero;
    wire code_match_one;
    wire code_match_two;
    wire code_match_three;
    wire code_match_four;
    wire code_match_five;
    wire code_match_six;
    wire code_match_seven;

    // bus wait-state handshake, answer at the second edge
    ppm_avs_wait u_wait (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_read(i_avs_read),
        .i_write(i_avs_write),
        .o_waitrequest(o_avs_waitrequest),
        .o_ack(ack_q)
    );

    // write lands at the acknowledged edge on lane 0; read loads in the wait cycle
    assign wr_take = i_avs_write & ack_q & i_avs_byteenable[0];
    assign rd_load = i_avs_read & ~ack_q;

    // low mapping register, codes 0 to 3
    ppm_map_reg #(
        .ADDR(`PPM_ADDR_MAP_LOW),
        .RST_VAL(`PPM_RST_MAP_LOW)
    ) u_map_low (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_address(i_avs_address),
        .i_wr_take(wr_take),
        .i_wr_data(i_avs_writedata[7:0]),
        .o_hit(hit_low),
        .o_value(map_low_q)
    );

    // high mapping register, codes 4 to 7
    ppm_map_reg #(
        .ADDR(`PPM_ADDR_MAP_HIGH),
        .RST_VAL(`PPM_RST_MAP_HIGH)
    ) u_map_high (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_address(i_avs_address),
        .i_wr_take(wr_take),
        .i_wr_data(i_avs_writedata[7:0]),
        .o_hit(hit_high),
        .o_value(map_high_q)
    );

    // readback of the addressed register, zero when unmapped
    always @* begin
        rdata_d = 8'h00;
        if (hit_low) begin
            rdata_d = map_low_q;
        end else if (hit_high) begin
            rdata_d = map_high_q;
        end
    end

    // read data loaded in the wait cycle, upper bytes zero
    always @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (rd_load) begin
            o_avs_readdata <= {24'h00_0000, rdata_d};
        end
    end

    // code 0 field, low map bits 1:0
    ppm_field_pick #(
        .POS(`PPM_POS_CODE_ZERO),
        .CODE(3'h0)
    ) u_pick_zero (
        .i_map(map_low_q),
        .i_code(i_priority_code),
        .o_queue(queue_for_code_zero),
        .o_hit(code_match_zero)
    );

    // code 1 field, low map bits 3:2
    ppm_field_pick #(
        .POS(`PPM_POS_CODE_ONE),
        .CODE(3'h1)
    ) u_pick_one (
        .i_map(map_low_q),
        .i_code(i_priority_code),
        .o_queue(queue_for_code_one),
        .o_hit(code_match_one)
    );

    // code 2 field, low map bits 5:4
    ppm_field_pick #(
        .POS(`PPM_POS_CODE_TWO),
        .CODE(3'h2)
    ) u_pick_two (
        .i_map(map_low_q),
        .i_code(i_priority_code),
        .o_queue(queue_for_code_two),
        .o_hit(code_match_two)
    );

    // code 3 field, low map bits 7:6
    ppm_field_pick #(
        .POS(`PPM_POS_CODE_THREE),
        .CODE(3'h3)
    ) u_pick_three (
        .i_map(map_low_q),
        .i_code(i_priority_code),
        .o_queue(queue_for_code_three),
        .o_hit(code_match_three)
    );

    // code 4 field, high map bits 1:0
    ppm_field_pick #(
        .POS(`PPM_POS_CODE_FOUR),
        .CODE(3'h4)
    ) u_pick_four (
        .i_map(map_high_q),
        .i_code(i_priority_code),
        .o_queue(queue_for_code_four),
        .o_hit(code_match_four)
    );

    // code 5 field, high map bits 3:2
    ppm_field_pick #(
        .POS(`PPM_POS_CODE_FIVE),
        .CODE(3'h5)
    ) u_pick_five (
        .i_map(map_high_q),
        .i_code(i_priority_code),
        .o_queue(queue_for_code_five),
        .o_hit(code_match_five)
    );

    // code 6 field, high map bits 5:4
    ppm_field_pick #(
        .POS(`PPM_POS_CODE_SIX),
        .CODE(3'h6)
    ) u_pick_six (
        .i_map(map_high_q),
        .i_code(i_priority_code),
        .o_queue(queue_for_code_six),
        .o_hit(code_match_six)
    );

    // code 7 field, high map bits 7:6
    ppm_field_pick #(
        .POS(`PPM_POS_CODE_SEVEN),
        .CODE(3'h7)
    ) u_pick_seven (
        .i_map(map_high_q),
        .i_code(i_priority_code),
        .o_queue(queue_for_code_seven),
        .o_hit(code_match_seven)
    );

    // code to queue selection, exactly one code matches
    always @* begin
        queue_d = ({2{code_match_zero}} & queue_for_code_zero)
            | ({2{code_match_one}} & queue_for_code_one)
            | ({2{code_match_two}} & queue_for_code_two)
            | ({2{code_match_three}} & queue_for_code_three)
            | ({2{code_match_four}} & queue_for_code_four)
            | ({2{code_match_five}} & queue_for_code_five)
            | ({2{code_match_six}} & queue_for_code_six)
            | ({2{code_match_seven}} & queue_for_code_seven);
    end

    // registered queue select holds until the next lookup; queue valid is a one-cycle pulse after each lookup
    always @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_queue_valid <= 1'b0;
            o_queue_sel <= 2'h0;
        end else begin
            o_queue_valid <= i_lookup_valid;
            if (i_lookup_valid) begin
                o_queue_sel <= queue_d;
            end
        end
    end

endmodule

// ===== core/ppm_regs.vh
`ifndef PPM_REGS_VH
`define PPM_REGS_VH

// register indices and byte addresses (index times four)
`define PPM_IDX_MAP_LOW 8'h80
`define PPM_IDX_MAP_HIGH 8'h81
`define PPM_ADDR_MAP_LOW 10'h200
`define PPM_ADDR_MAP_HIGH 10'h204
`define PPM_ADDR_W 10

// field positions (low bit of each 2-bit field)
`define PPM_FLD_W 2
`define PPM_POS_CODE_THREE 6
`define PPM_POS_CODE_TWO 4
`define PPM_POS_CODE_ONE 2
`define PPM_POS_CODE_ZERO 0
`define PPM_POS_CODE_SEVEN 6
`define PPM_POS_CODE_SIX 4
`define PPM_POS_CODE_FIVE 2
`define PPM_POS_CODE_FOUR 0

// reset values
`define PPM_RST_MAP_LOW 8'h50
`define PPM_RST_MAP_HIGH 8'hfa

// lookup latency in clock cycles
`define PPM_LOOKUP_CYCLES 1

`endif

// ===== testbench/ppm_priority_mapper_props.sv
`timescale 1ns/1ps
module ppm_priority_mapper_props (
    input wire i_ref_clk, input wire i_srst,
    input wire [9:0] i_avs_address, input wire i_avs_read, input wire i_avs_write,
    input wire [31:0] i_avs_writedata, input wire [3:0] i_avs_byteenable,
    input wire [31:0] o_avs_readdata, input wire o_avs_waitrequest,
    input wire i_lookup_valid, input wire [2:0] i_priority_code,
    input wire o_queue_valid, input wire [1:0] o_queue_sel
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);
    reg [15:0] map_q;
    reg [1:0] exp_q;
    wire hit = {i_avs_address[9:3], i_avs_address[1:0]} == 9'h100;
    // shadow of both maps, high byte on top
    always @(posedge i_ref_clk) begin
        exp_q <= map_q[{i_priority_code, 1'b0} +: 2];
        if (i_srst) map_q <= 16'hfa50;
        else if (i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0] && hit)
            map_q[i_avs_address[2]*8 +: 8] <= i_avs_writedata[7:0];
    end
    sequence s_req; (i_avs_read || i_avs_write) && o_avs_waitrequest; endsequence
    a_map_sel: assert property (i_lookup_valid |=> o_queue_sel == exp_q)
        else $error("queue differs from map");
    a_valid_lat: assert property (i_lookup_valid |=> o_queue_valid) else $error("no queue pulse");
    a_no_spur: assert property (!i_lookup_valid |=> !o_queue_valid) else $error("stray pulse");
    a_sel_hold: assert property (!i_lookup_valid |=> $stable(o_queue_sel))
        else $error("queue changed idle");
    a_wait_one: assert property (s_req |=> !o_avs_waitrequest) else $error("wait too long");
    a_wait_idle: assert property (!i_avs_read && !i_avs_write |-> !o_avs_waitrequest)
        else $error("wait while idle");
    a_rd_data: assert property (i_avs_read && !o_avs_waitrequest && hit
        |-> o_avs_readdata == {24'h0, map_q[i_avs_address[2]*8 +: 8]}) else $error("bad read");
    a_rd_unmap: assert property (i_avs_read && !o_avs_waitrequest && !hit
        |-> o_avs_readdata == 32'h0) else $error("unmapped read");
endmodule
bind ppm_priority_mapper ppm_priority_mapper_props u_props (.*);

// ===== testbench/pcp_priority_mapper_tb_top.sv
`timescale 1ns/1ps
module pcp_priority_mapper_tb_top;
    reg clk = 0, rst = 1, rd = 0, wr = 0, lv = 0;
    reg [9:0] a = 0;
    reg [31:0] wd = 0;
    reg [3:0] be = 4'hf;
    reg [2:0] pc = 0;
    reg [15:0] m;
    wire [31:0] rdat;
    wire wq, qv;
    wire [1:0] qs;
    integer error_cnt = 0, num_checks = 0, cyc = 0, i;
    ppm_priority_mapper DUT (.i_ref_clk(clk), .i_srst(rst), .i_avs_address(a), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wq), .i_lookup_valid(lv), .i_priority_code(pc),
        .o_queue_valid(qv), .o_queue_sel(qs));
    always #25 clk = ~clk;
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 2000) begin
            error_cnt = error_cnt + 1;
            final_report;
        end
    end
    task chk(input string n, input [31:0] e, input [31:0] g);
        num_checks = num_checks + 1;
        if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // one avalon access, held until the rising edge that sees waitrequest low
    task bus(input w, input [9:0] ad, input [31:0] d, input [3:0] b, input [31:0] e);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        a <= ad;
        wd <= d;
        be <= b;
        @(posedge clk);
        while (wq !== 1'b0) @(posedge clk);
        if (!w) chk("readdata", e, rdat);
        rd <= 0;
        wr <= 0;
    endtask
    // look up every code against map m
    task sweep;
        for (i = 0; i < 8; i = i + 1) begin
            @(posedge clk);
            lv <= 1;
            pc <= i[2:0];
            @(posedge clk);
            lv <= 0;
            @(negedge clk);
            chk("queue", {29'h0, 1'b1, m[2*i +: 2]}, {29'h0, qv, qs});
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        bus(0, 10'h200, 0, 4'hf, 32'h50);
        bus(0, 10'h204, 0, 4'hf, 32'hfa);
        m = 16'hfa50;
        sweep;
        $display("test defaults done");
        bus(1, 10'h200, 32'h1b, 4'hf, 0);
        bus(1, 10'h204, 32'he4, 4'hf, 0);
        bus(1, 10'h204, 32'h00, 4'he, 0);
        bus(1, 10'h208, 32'hff, 4'hf, 0);
        bus(0, 10'h204, 0, 4'hf, 32'he4);
        bus(0, 10'h208, 0, 4'hf, 0);
        m = 16'he41b;
        sweep;
        $display("test remap done");
        final_report;
    end
endmodule
